/* hw/clk_ctrl_pkg.sv */
// constants and types for the clock synthesizer output control block
// Operation
// RULE_01 - test mode divides crystal-pin test clock; mid/00 floats outputs; mid/1x reserved
// RULE_02 - under-clock margining keeps the 200 MHz dividers, only slows the VCO
// RULE_03 - serial slave accepts block writes only; block read is not supported
// RULE_04 - bytes arrive ascending, msb first; stop after any whole byte keeps them
// RULE_05 - slave answers address byte 0xd2, write direction only
// RULE_06 - command code after address must be 0x00, then a byte count
// RULE_07 - byte count gives number of data bytes; it bounds the data phase
// RULE_08 - host sends a byte count from 1 to 32, never zero
// RULE_09 - transfer is valid once the byte count acknowledge was sampled by host
// RULE_10 - all configuration bits load defaults at power-up; no access needed
// RULE_11 - control bit 7 enables down-spread, default off
// RULE_12 - control bit 5 picks shared output 66 MHz (0) or 48 MHz (1)
// RULE_13 - control bit 4 reads the live cpu stop pin
// RULE_14 - control bit 3 stops the seven stoppable pci outputs only
// RULE_15 - control bits 2..0 read straps latched at power-up
// RULE_16 - power-down: cpu true at 2x current, complements float, rest low, vco off
// RULE_17 - normal modes: reference at crystal rate, 48 MHz outputs fixed
// RULE_18 - frequency straps pick cpu 66/100/200/133 MHz; fixed 66 outputs unchanged
// RULE_19 - mode high buffers external 66 input, pci at half; low uses vco
// RULE_20 - straps sampled while power-good strobe low, strobe ignored afterwards
// RULE_21 - stop pins halt pci and non-free-running cpu pairs; clean restart
package clk_ctrl_pkg;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_LOW  = 2'b00,
    MODE_HIGH = 2'b01,
    MODE_MID  = 2'b10,
    MODE_BAD  = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    CPU_66  = 2'b00,
    CPU_100 = 2'b01,
    CPU_200 = 2'b10,
    CPU_133 = 2'b11
  } cpu_freq_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_CMD  = 3'b010,
    ST_CNT  = 3'b011,
    ST_DATA = 3'b100,
    ST_SKIP = 3'b101
  } smb_state_t;

  // ----------------------------------------------------------------
  // serial protocol values
  // ----------------------------------------------------------------
  localparam logic [7:0] SLAVE_ADDR  = 8'hd2;
  localparam logic [7:0] CMD_CODE    = 8'h00;
  localparam logic [5:0] CNT_MIN     = 6'h01;
  localparam logic [5:0] CNT_MAX     = 6'h20;
  localparam logic [3:0] BITS_BYTE   = 4'h8;

  // ----------------------------------------------------------------
  // control byte 0 layout and reset
  // ----------------------------------------------------------------
  localparam int         BIT_SPREAD  = 7;
  localparam int         BIT_VIDEO   = 5;
  localparam int         BIT_CPUSTOP = 4;
  localparam int         BIT_PCISTOP = 3;
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [7:0] CTRL_WMASK  = 8'ha8;

  // ----------------------------------------------------------------
  // pin synchroniser bus: {pg,pd,cst,pst,scl,sda,xtal,marg,mode,hi,lo}
  // ----------------------------------------------------------------
  localparam int          SYNC_W     = 12;
  localparam logic [11:0] SYNC_RST   = 12'hfc0;
  localparam logic [2:0]  STRAP_RST  = 3'h0;

endpackage : clk_ctrl_pkg

/* hw/pin_sync3.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter int          W       = 12,
  parameter logic [W-1:0] RST_VAL = 12'hfc0
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // pins and filtered levels
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_ff
);

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic lvl_ff;
      // s1 feeds s2 only; a change counts when s2 and s3 agree
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_ff       <= RST_VAL[i];
          s2_ff       <= RST_VAL[i];
          s3_ff       <= RST_VAL[i];
          lvl_ff      <= RST_VAL[i];
        end
        else
        begin
          s1_ff <= pin_in[i];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff)
            lvl_ff <= s3_ff;
        end
      end
      // one flop per bit keeps each bit of the bus with a single driver
      assign level_ff[i] = lvl_ff;
    end
  endgenerate

endmodule : pin_sync3
`default_nettype wire

/* hw/test_clk_div.sv */
// divider chain for the test clock sampled on the crystal pin
`timescale 1ns/1ps
`default_nettype none
module test_clk_div (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // one-cycle pulse per rising test clock edge
  input  wire logic       tick,
  // bit0 = /2, bit1 = /4, bit2 = /8
  output logic      [2:0] div_ff
);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_ff <= 3'h0;
    else if (tick)
      div_ff <= div_ff + 3'h1; // RULE_01
  end

endmodule : test_clk_div
`default_nettype wire

/* hw/clk_out_ctrl.sv */
// output gating, strap capture and serial configuration slave
`timescale 1ns/1ps
`default_nettype none
module clk_out_ctrl #(
  parameter logic [2:0] CPU_FREE_RUN = 3'h0
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // straps
  input  wire logic       power_good_strobe_n,
  input  wire logic [1:0] mode_strap,
  input  wire logic       freq_strap_hi,
  input  wire logic       freq_strap_lo,
  // power management pins
  input  wire logic       power_down_n,
  input  wire logic       cpu_stop_n,
  input  wire logic       pci_stop_n,
  input  wire logic       under_clock_req,
  // crystal pin, carries the test clock in test mode
  input  wire logic       crystal_input,
  // serial configuration port
  input  wire logic       smb_scl_in,
  input  wire logic       smb_sda_in,
  output logic            smb_sda_out_ff,
  output logic            smb_sda_oe_ff,
  // cpu group
  output logic      [2:0] cpu_run_ff,
  output logic            cpu_iref2_ff,
  output logic            cpu_comp_float_ff,
  output logic      [1:0] cpu_freq_ff,
  output logic      [1:0] cpu_div_ff,
  // 66 MHz and pci groups
  output logic            fixed_66_run_ff,
  output logic            buffered_66_ext_ff,
  output logic      [6:0] pci_run_ff,
  output logic      [2:0] pci_free_run_ff,
  output logic            shared_video_48_ff,
  // reference and 48 MHz
  output logic            ref_48_run_ff,
  // synthesizer
  output logic            vco_on_ff,
  output logic            vco_slow_ff,
  output logic            spread_on_ff,
  output logic            all_hiz_ff,
  // test mode flag, divided test clocks and undivided crystal reference
  output logic            test_mode_ff,
  output logic            test_cpu_ff,
  output logic            test_66_ff,
  output logic            test_pci_ff,
  output logic            test_ref_ff,
  // configuration view
  output logic      [7:0] ctrl_byte_ff,
  output logic            xfer_valid_ff
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [11:0] lvl;

  pin_sync3 #(
    .W       (clk_ctrl_pkg::SYNC_W),
    .RST_VAL (clk_ctrl_pkg::SYNC_RST)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin_in   ({power_good_strobe_n, power_down_n, cpu_stop_n, pci_stop_n,
                smb_scl_in, smb_sda_in, crystal_input, under_clock_req,
                mode_strap, freq_strap_hi, freq_strap_lo}),
    .level_ff (lvl)
  );

  wire       pg_n_s   = lvl[11];
  wire       pd_n_s   = lvl[10];
  wire       cstop_n  = lvl[9];
  wire       pstop_n  = lvl[8];
  wire       scl_s    = lvl[7];
  wire       sda_s    = lvl[6];
  wire       xtal_s   = lvl[5];
  wire       margin_s = lvl[4];
  wire [3:0] straps_s = lvl[3:0];

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  logic [3:0] strap_ff;
  logic       strap_done_ff;
  logic       strap_seen_ff;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_ff      <= 4'h0;
      strap_done_ff <= 1'b0;
    end
    else if (!strap_done_ff)
    begin
      if (!pg_n_s)
        strap_ff <= straps_s; // RULE_20
      if (pg_n_s && strap_seen_ff)
        strap_done_ff <= 1'b1; // RULE_20
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      strap_seen_ff <= 1'b0;
    else if (!pg_n_s)
      strap_seen_ff <= 1'b1;
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  clk_ctrl_pkg::mode_t     mode;
  clk_ctrl_pkg::cpu_freq_t freq;

  assign mode = clk_ctrl_pkg::mode_t'(strap_ff[3:2]);
  assign freq = clk_ctrl_pkg::cpu_freq_t'(strap_ff[1:0]);

  logic [7:0] ctrl_ff;

  wire mid       = (mode == clk_ctrl_pkg::MODE_MID);
  wire ext66     = (mode == clk_ctrl_pkg::MODE_HIGH);
  // reserved mid codes float the outputs, the safest defined answer
  wire hiz       = mid && (freq != clk_ctrl_pkg::CPU_100); // RULE_01
  wire test      = mid && (freq == clk_ctrl_pkg::CPU_100); // RULE_01
  wire pd        = !pd_n_s;
  wire run       = !pd && !hiz;
  wire sw_pstop  = ctrl_ff[clk_ctrl_pkg::BIT_PCISTOP];

  // ----------------------------------------------------------------
  // test clock dividers
  // ----------------------------------------------------------------
  // the test clock is sampled, so it must stay well below core_clk / 2
  logic       xtal_q_ff;
  logic [2:0] tdiv;
  wire        xtal_rise = xtal_s && !xtal_q_ff;

  test_clk_div u_tdiv (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (xtal_rise && test),
    .div_ff   (tdiv)
  );

  // ----------------------------------------------------------------
  // output next values
  // ----------------------------------------------------------------
  wire [2:0] nxt_cpu_run  = run ? (CPU_FREE_RUN | {3{cstop_n}}) : 3'h0; // RULE_21
  wire [6:0] nxt_pci_run  = (run && pstop_n && !sw_pstop) ? 7'h7f : 7'h00; // RULE_14
  wire [2:0] nxt_pci_free = run ? 3'h7 : 3'h0; // RULE_14
  wire [1:0] nxt_cpu_div  = margin_s ? clk_ctrl_pkg::CPU_200 : freq; // RULE_02
  wire       tgate        = test && !pd;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xtal_q_ff          <= 1'b0;
      cpu_run_ff         <= 3'h0;
      cpu_iref2_ff       <= 1'b0;
      cpu_comp_float_ff  <= 1'b0;
      cpu_freq_ff        <= 2'h0;
      cpu_div_ff         <= 2'h0;
      fixed_66_run_ff    <= 1'b0;
      buffered_66_ext_ff <= 1'b0;
      pci_run_ff         <= 7'h00;
      pci_free_run_ff    <= 3'h0;
      shared_video_48_ff <= 1'b0;
      ref_48_run_ff      <= 1'b0;
      vco_on_ff          <= 1'b0;
      vco_slow_ff        <= 1'b0;
      spread_on_ff       <= 1'b0;
      all_hiz_ff         <= 1'b0;
    end
    else
    begin
      xtal_q_ff          <= xtal_s;
      cpu_run_ff         <= nxt_cpu_run; // RULE_21
      cpu_iref2_ff       <= pd; // RULE_16
      cpu_comp_float_ff  <= pd; // RULE_16
      cpu_freq_ff        <= freq; // RULE_18
      cpu_div_ff         <= nxt_cpu_div; // RULE_02
      fixed_66_run_ff    <= run; // RULE_18
      buffered_66_ext_ff <= ext66; // RULE_19
      pci_run_ff         <= nxt_pci_run; // RULE_21
      pci_free_run_ff    <= nxt_pci_free;
      shared_video_48_ff <= ctrl_ff[clk_ctrl_pkg::BIT_VIDEO]; // RULE_12
      ref_48_run_ff      <= run && !test; // RULE_17
      vco_on_ff          <= !pd; // RULE_16
      vco_slow_ff        <= margin_s && !pd; // RULE_02
      spread_on_ff       <= ctrl_ff[clk_ctrl_pkg::BIT_SPREAD]; // RULE_11
      all_hiz_ff         <= hiz && !pd; // RULE_01
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      test_mode_ff <= 1'b0;
      test_cpu_ff  <= 1'b0;
      test_66_ff   <= 1'b0;
      test_pci_ff  <= 1'b0;
      test_ref_ff  <= 1'b0;
    end
    else
    begin
      test_mode_ff <= tgate;
      test_cpu_ff  <= tgate && tdiv[0]; // RULE_01
      test_66_ff   <= tgate && tdiv[1]; // RULE_01
      test_pci_ff  <= tgate && tdiv[2]; // RULE_01
      test_ref_ff  <= tgate && xtal_s; // RULE_01
    end
  end

  // ----------------------------------------------------------------
  // serial slave: bus conditions
  // ----------------------------------------------------------------
  logic scl_q_ff;
  logic sda_q_ff;

  wire scl_rise = scl_s && !scl_q_ff;
  wire scl_fall = !scl_s && scl_q_ff;
  wire start_c  = scl_s && scl_q_ff && sda_q_ff && !sda_s;
  wire stop_c   = scl_s && scl_q_ff && !sda_q_ff && sda_s;

  // ----------------------------------------------------------------
  // serial slave: byte engine
  // ----------------------------------------------------------------
  clk_ctrl_pkg::smb_state_t st_ff;
  logic [7:0] shift_ff;
  logic [3:0] bit_cnt_ff;
  logic       ack_ff;
  logic [5:0] remain_ff;
  logic [5:0] idx_ff;

  wire byte_done = scl_fall && !ack_ff && (bit_cnt_ff == clk_ctrl_pkg::BITS_BYTE);
  wire ack_end   = scl_fall && ack_ff;
  wire cnt_ok    = (shift_ff[7:6] == 2'h0) && (shift_ff[5:0] >= clk_ctrl_pkg::CNT_MIN)
                   && (shift_ff[5:0] <= clk_ctrl_pkg::CNT_MAX);
  wire cnt_big   = (shift_ff == 8'h20);

  logic byte_ok;
  always_comb
  begin
    unique case (st_ff)
      clk_ctrl_pkg::ST_ADDR: byte_ok = (shift_ff == clk_ctrl_pkg::SLAVE_ADDR); // RULE_05
      clk_ctrl_pkg::ST_CMD:  byte_ok = (shift_ff == clk_ctrl_pkg::CMD_CODE); // RULE_06
      clk_ctrl_pkg::ST_CNT:  byte_ok = cnt_ok || cnt_big; // RULE_08
      clk_ctrl_pkg::ST_DATA: byte_ok = (remain_ff != 6'h00); // RULE_07
      default:               byte_ok = 1'b0;
    endcase
  end

  wire wr_ctrl = ack_end && (st_ff == clk_ctrl_pkg::ST_DATA) && (idx_ff == 6'h00);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      shift_ff <= 8'h00;
    end
    else
    begin
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
      if (scl_rise && !ack_ff && (st_ff != clk_ctrl_pkg::ST_IDLE))
        shift_ff <= {shift_ff[6:0], sda_s}; // RULE_04
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff         <= clk_ctrl_pkg::ST_IDLE;
      bit_cnt_ff    <= 4'h0;
      ack_ff        <= 1'b0;
      smb_sda_oe_ff <= 1'b0;
      xfer_valid_ff <= 1'b0;
    end
    else if (start_c)
    begin
      st_ff         <= clk_ctrl_pkg::ST_ADDR;
      bit_cnt_ff    <= 4'h0;
      ack_ff        <= 1'b0;
      smb_sda_oe_ff <= 1'b0;
      xfer_valid_ff <= 1'b0;
    end
    else if (stop_c)
    begin
      st_ff         <= clk_ctrl_pkg::ST_IDLE;
      ack_ff        <= 1'b0;
      smb_sda_oe_ff <= 1'b0;
    end
    else if (scl_rise && !ack_ff && (st_ff != clk_ctrl_pkg::ST_IDLE))
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
    else if (byte_done && byte_ok)
    begin
      ack_ff        <= 1'b1;
      smb_sda_oe_ff <= 1'b1; // RULE_03
    end
    else if (byte_done)
      st_ff <= clk_ctrl_pkg::ST_SKIP; // RULE_03
    else if (ack_end)
    begin
      ack_ff        <= 1'b0;
      smb_sda_oe_ff <= 1'b0;
      bit_cnt_ff    <= 4'h0;
      unique case (st_ff)
        clk_ctrl_pkg::ST_ADDR: st_ff <= clk_ctrl_pkg::ST_CMD;
        clk_ctrl_pkg::ST_CMD:  st_ff <= clk_ctrl_pkg::ST_CNT;
        clk_ctrl_pkg::ST_CNT:
        begin
          st_ff         <= clk_ctrl_pkg::ST_DATA;
          xfer_valid_ff <= 1'b1; // RULE_09
        end
        default:               st_ff <= st_ff;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      remain_ff <= 6'h00;
      idx_ff    <= 6'h00;
    end
    else if (ack_end && (st_ff == clk_ctrl_pkg::ST_CNT))
    begin
      remain_ff <= shift_ff[5:0]; // RULE_07
      idx_ff    <= 6'h00;
    end
    else if (ack_end && (st_ff == clk_ctrl_pkg::ST_DATA))
    begin
      remain_ff <= remain_ff - 6'h01; // RULE_07
      idx_ff    <= idx_ff + 6'h01; // RULE_04
    end
  end

  // ----------------------------------------------------------------
  // control byte 0
  // ----------------------------------------------------------------
  // only bits 7, 5 and 3 are writable; bit 6 reads 0, bits 4 and 2..0 show pin and strap state
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_ff <= clk_ctrl_pkg::CTRL_RST; // RULE_10
    else if (wr_ctrl && xfer_valid_ff)
      ctrl_ff <= shift_ff & clk_ctrl_pkg::CTRL_WMASK; // RULE_11
  end

  wire [7:0] nxt_ctrl_view = {ctrl_ff[7:5], cstop_n, ctrl_ff[3], ext66, strap_ff[1:0]}; // RULE_15

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_byte_ff   <= clk_ctrl_pkg::CTRL_RST;
      smb_sda_out_ff <= 1'b0;
    end
    else
    begin
      ctrl_byte_ff   <= nxt_ctrl_view; // RULE_13
      smb_sda_out_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_pd_cpu_drive: assert property (pd |=> cpu_iref2_ff && cpu_comp_float_ff // RULE_16
    && pci_run_ff == 7'h00 && !vco_on_ff && !fixed_66_run_ff)
    else $error("power-down output state wrong");
  a_pci_free_kept: assert property (run && !pstop_n |=> pci_run_ff == 7'h00 // RULE_14
    && pci_free_run_ff == 3'h7)
    else $error("pci stop hit free-running outputs");
  a_addr_match: assert property (byte_done && st_ff == clk_ctrl_pkg::ST_ADDR // RULE_05
    && shift_ff != 8'hd2 |=> !smb_sda_oe_ff [*2])
    else $error("foreign address acknowledged");
  a_cmd_code: assert property (byte_done && st_ff == clk_ctrl_pkg::ST_CMD // RULE_06
    && shift_ff == 8'h00 |=> smb_sda_oe_ff)
    else $error("zero command not acknowledged");
  a_cnt_zero: assert property (byte_done && st_ff == clk_ctrl_pkg::ST_CNT // RULE_08
    && shift_ff == 8'h00 |=> st_ff == clk_ctrl_pkg::ST_SKIP && !smb_sda_oe_ff)
    else $error("zero byte count accepted");
  a_valid_cause: assert property ($rose(xfer_valid_ff) |-> // RULE_09
    $past(ack_end) && $past(st_ff) == clk_ctrl_pkg::ST_CNT)
    else $error("valid without count acknowledge");
  a_ctrl_write: assert property (wr_ctrl && xfer_valid_ff |=> // RULE_11
    ctrl_ff == ($past(shift_ff) & 8'ha8) ##1 ctrl_byte_ff[7] == ctrl_ff[7])
    else $error("control byte not written");
  a_strap_hold: assert property (strap_done_ff |=> $stable(strap_ff)) // RULE_20
    else $error("straps changed after capture");
  a_margin_div: assert property (margin_s |=> cpu_div_ff == clk_ctrl_pkg::CPU_200) // RULE_02
    else $error("margining changed the cpu divider");

  c_block_write: cover property (wr_ctrl && xfer_valid_ff);
  c_power_down: cover property ($rose(cpu_iref2_ff));
  c_test_mode: cover property (test_mode_ff && test_pci_ff);

endmodule : clk_out_ctrl
`default_nettype wire

/* sim/smb_host_model.sv */
// serial host controller model that sends block writes on open-drain lines
`timescale 1ns/1ps
`default_nettype none
module smb_host_model (
  // clock
  input  wire logic core_clk,
  // device pull-down and wire levels
  input  wire logic dev_pull,
  output logic      scl,
  output logic      sda
);
  // ------------------------------
  // wire model
  // ------------------------------
  logic drv_low = 1'b0;
  logic smp;
  initial scl = 1'b1;
  // pull-up: line is high unless a party pulls it low
  assign sda = ~(drv_low | dev_pull);

  // ------------------------------
  // bus cycles
  // ------------------------------
  task automatic hp();
    repeat (10) @(posedge core_clk);
  endtask : hp

  // data moves only well inside scl low, so no false start or stop is seen
  task automatic bitx(input logic v);
    repeat (3) @(posedge core_clk);
    drv_low <= ~v;
    hp();
    scl <= 1'b1;
    hp();
    smp = sda;
    scl <= 1'b0;
  endtask : bitx

  // start, bytes msb first each with an ack slot, stop after any whole byte
  task automatic send(input logic [7:0] q[$], output int acks);
    acks = 0;
    drv_low <= 1'b1;
    hp();
    scl <= 1'b0;
    foreach (q[i])
    begin
      for (int b = 7; b >= 0; b--) bitx(q[i][b]);
      bitx(1'b1);
      if (smp === 1'b0) acks++;
    end
    repeat (3) @(posedge core_clk);
    drv_low <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    drv_low <= 1'b0;
    hp();
  endtask : send
endmodule : smb_host_model
`default_nettype wire

/* sim/clock_synth_output_control_test.sv */
// self-checking bench for the clock output control block
`timescale 1ns/1ps
`default_nettype none
module clock_synth_output_control_test;
  // ------------------------------
  // signals
  // ------------------------------
  logic core_clk = 1'b0, rst_n = 1'b0, pg_n = 1'b1, pd_n = 1'b1, cs_n = 1'b1;
  logic ps_n = 1'b1, ucr = 1'b0, xtal = 1'b0, cnt_en = 1'b0;
  logic [1:0] ms = 2'h0, fs = 2'h0;
  logic [3:0] tp = 4'h0;
  wire logic scl, sda, oe, iref2, cfl, f66, b66, v48, r48, vco, vslow, spr, hiz;
  wire logic tm, t_cpu, t_66, t_pci, t_ref, xv;
  wire logic [1:0] cfreq, cdiv;
  wire logic [2:0] crun, pfree;
  wire logic [6:0] prun;
  wire logic [7:0] ctrl;
  wire logic [3:0] tv = {t_pci, t_66, t_cpu, t_ref};
  int rc[4];
  int err_count = 0, total_checks = 0, cyc = 0, acks;

  clk_out_ctrl i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .power_good_strobe_n(pg_n),
    .mode_strap(ms), .freq_strap_hi(fs[1]), .freq_strap_lo(fs[0]),
    .power_down_n(pd_n), .cpu_stop_n(cs_n), .pci_stop_n(ps_n),
    .under_clock_req(ucr), .crystal_input(xtal), .smb_scl_in(scl),
    .smb_sda_in(sda), .smb_sda_out_ff(), .smb_sda_oe_ff(oe), .cpu_run_ff(crun),
    .cpu_iref2_ff(iref2), .cpu_comp_float_ff(cfl), .cpu_freq_ff(cfreq),
    .cpu_div_ff(cdiv), .fixed_66_run_ff(f66), .buffered_66_ext_ff(b66),
    .pci_run_ff(prun), .pci_free_run_ff(pfree), .shared_video_48_ff(v48),
    .ref_48_run_ff(r48), .vco_on_ff(vco), .vco_slow_ff(vslow),
    .spread_on_ff(spr), .all_hiz_ff(hiz), .test_mode_ff(tm), .test_cpu_ff(t_cpu),
    .test_66_ff(t_66), .test_pci_ff(t_pci), .test_ref_ff(t_ref),
    .ctrl_byte_ff(ctrl), .xfer_valid_ff(xv)
  );
  smb_host_model i_host (.core_clk(core_clk), .dev_pull(oe), .scl(scl), .sda(sda));

  // ------------------------------
  // clock, crystal, edge counters, timeout
  // ------------------------------
  initial forever #25 core_clk = ~core_clk;

  // crystal period of 20 cycles keeps the sampled test clock exactly periodic
  always
  begin
    repeat (10) @(posedge core_clk);
    xtal <= ~xtal;
  end

  always @(posedge core_clk)
  begin
    tp <= tv;
    for (int i = 0; i < 4; i++)
      if (cnt_en && tp[i] === 1'b0 && tv[i] === 1'b1) rc[i]++;
  end

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      summarize();
    end
  end

  // ------------------------------
  // tasks
  // ------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wt

  // reset, then one power-good pulse to latch the straps
  task automatic boot(input logic [1:0] m, input logic [1:0] f);
    @(posedge core_clk);
    rst_n <= 1'b0;
    ms <= m;
    fs <= f;
    wt(2);
    rst_n <= 1'b1;
    wt(6);
    pg_n <= 1'b0;
    wt(8);
    pg_n <= 1'b1;
    wt(8);
  endtask : boot

  task automatic wr(input logic [7:0] q[$], input int exp);
    i_host.send(q, acks);
    wt(8);
    chk(acks, exp);
  endtask : wr

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // ------------------------------
  // sequence
  // ------------------------------
  initial
  begin
    for (int m = 0; m < 2; m++)
      for (int f = 0; f < 4; f++)
      begin
        boot(m[1:0], f[1:0]);
        chk(cfreq, f);
        chk(b66, m);
        chk(ctrl[2:0], {m[0], f[1:0]});
        chk({r48, f66, hiz, tm}, 4'hc);
      end
    // straps stay frozen once power-good has been seen
    fs <= 2'h1;
    pg_n <= 1'b0;
    wt(8);
    pg_n <= 1'b1;
    wt(8);
    chk(cfreq, 2'h3);
    ucr <= 1'b1;
    wt(8);
    chk({cdiv, vslow}, 3'h5);
    ucr <= 1'b0;
    boot(2'h2, 2'h0);
    chk(hiz, 1);
    boot(2'h2, 2'h2);
    chk(hiz, 1);
    boot(2'h2, 2'h1);
    cnt_en <= 1'b1;
    wt(320);
    cnt_en <= 1'b0;
    wt(1);
    chk({tm, hiz}, 2'h2);
    foreach (rc[i]) chk(rc[i], 16 >> i);
    boot(2'h0, 2'h2);
    ps_n <= 1'b0;
    cs_n <= 1'b0;
    wt(8);
    chk({crun, prun, pfree, ctrl[4]}, {3'h0, 7'h00, 3'h7, 1'b0});
    cs_n <= 1'b1;
    ps_n <= 1'b1;
    wt(8);
    chk({crun, prun, ctrl[4]}, {3'h7, 7'h7f, 1'b1});
    pd_n <= 1'b0;
    cs_n <= 1'b0;
    wt(8);
    chk({iref2, cfl, vco, f66, r48, prun, pfree}, {5'h18, 7'h00, 3'h0});
    pd_n <= 1'b1;
    cs_n <= 1'b1;
    wt(8);
    chk(vco, 1);
    chk({ctrl[7:3], spr, v48, xv}, 8'h10);
    wr('{8'hd2, 8'h00, 8'h01, 8'hff}, 4);
    chk(ctrl, 8'hba);
    chk({spr, v48, xv}, 3'h7);
    chk({prun, pfree}, {7'h00, 3'h7});
    wr('{8'hd3, 8'h00, 8'h01, 8'h00}, 0);
    chk(xv, 0);
    wr('{8'hd0, 8'h00, 8'h01, 8'h00}, 0);
    wr('{8'hd2, 8'h01, 8'h01, 8'h00}, 1);
    wr('{8'hd2, 8'h00, 8'h00, 8'h00}, 2);
    wr('{8'hd2, 8'h00, 8'h21, 8'h00}, 2);
    wr('{8'hd2, 8'h00, 8'h20}, 3);
    chk({ctrl, xv}, {8'hba, 1'b1});
    wr('{8'hd2, 8'h00, 8'h01, 8'h00, 8'h00}, 4);
    chk(ctrl, 8'h12);
    summarize();
  end
endmodule : clock_synth_output_control_test
`default_nettype wire
